// ---- lbt_bridge.sv ----
// Summary of operation
// - After reset and self-test, only learn for learn interval, then forward.
// - Each frame records its source and arrival port if its hash slot holds that source or is free with room.
// - Learning continues while forwarding.
// - Source is checked and entered before destination is evaluated.
// - Destination on the arrival segment: frame is discarded.
// - Unknown destination: forward and insert entry marked location unknown if its hash slot is free with room.
// - Source matching an unknown-location entry fills in its port.
// - Known remote destination: forward out the stored port.
// - Dynamic entry holds address, port and one freshness flag.
// - Lookup or insertion sets the entry's freshness flag.
// - Aging expiry scans table, deletes entries unused since last expiry.
// - Permanent entries live in a separate table, never aged.
// - Aged-out stations fall back to unknown handling and relearn.
// - Table holds 2048 entries; when full, no insert, unknown forwarding.
// - Full alarm once; again only after dropping by a third and refill.
`timescale 1ns/1ps
`default_nettype none
module lbt_bridge #(
  parameter int DYN_DEPTH = lbt_pkg::LBT_DYN_DEPTH,
  parameter int PERM_DEPTH = lbt_pkg::LBT_PERM_DEPTH,
  parameter int AW = $clog2(DYN_DEPTH)
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic selftest_done,
  input wire logic [lbt_pkg::LBT_CNT_W-1:0] learn_cycles,
  input wire logic [lbt_pkg::LBT_CNT_W-1:0] age_cycles,
  input wire lbt_pkg::lbt_frame_type frame,
  input wire logic frame_valid,
  output logic frame_ready,
  output lbt_pkg::lbt_dec_type decision,
  input wire lbt_pkg::lbt_mgmt_type mgmt,
  output logic mgmt_ack,
  output lbt_pkg::lbt_entry_type mgmt_rdata,
  output logic forwarding_mode,
  output logic table_full_alarm,
  output logic [AW:0] dyn_count
);
  import lbt_pkg::*;
  localparam int REARM_LVL = DYN_DEPTH - DYN_DEPTH * LBT_REARM_NUM
                             / LBT_REARM_DEN;
  localparam logic [AW:0] FULL = (AW+1)'(DYN_DEPTH);
  localparam logic [AW:0] REARM = (AW+1)'(REARM_LVL);
  localparam logic [AW-1:0] LAST = AW'(DYN_DEPTH - 1);
  localparam int PIW = $clog2(PERM_DEPTH);

  typedef enum logic [3:0] {
    ST_CLEAR, ST_IDLE, ST_SRC_WAIT, ST_SRC_CHK, ST_DST_WAIT, ST_DST_CHK,
    ST_SCAN_WAIT, ST_SCAN_CHK, ST_MGMT_WAIT, ST_MGMT_DO
  } lbt_state_type;

  lbt_state_type state, next_state;
  lbt_entry_type dyn_mem [DYN_DEPTH];
  lbt_entry_type perm_tab [PERM_DEPTH];
  lbt_entry_type rd_q, wr_data;
  lbt_frame_type frame_q;
  lbt_dec_type next_dec;
  logic [AW-1:0] rd_addr, next_rd_addr, wr_addr, idx, next_idx;
  logic [AW:0] next_count;
  logic wr_en, scan_pend, next_scan_pend, alarm_armed;
  logic learn_tick, age_tick, mgmt_take, perm_we;
  logic [LBT_HASH_W-1:0] src_h, dst_h;
  logic [PERM_DEPTH-1:0] perm_hit, perm_port_v;

  assign src_h = lbt_hash(frame_q.src);
  assign dst_h = lbt_hash(frame_q.dst);
  wire logic frame_take = (state == ST_IDLE) && frame_ready && frame_valid;
  wire logic hit_src = rd_q.valid && (rd_q.mac == frame_q.src);
  wire logic hit_dst = rd_q.valid && (rd_q.mac == frame_q.dst);
  wire logic room = dyn_count < FULL;
  wire logic perm_any = |perm_hit;
  // First permanent match wins; duplicates are management's concern
  wire logic perm_port = |(perm_port_v & perm_hit & (~perm_hit + 1'b1));
  wire logic dst_known = perm_any || (hit_dst && rd_q.known);
  wire logic dst_port = perm_any ? perm_port : rd_q.port;
  wire logic src_ins = !hit_src && !rd_q.valid && room;
  wire logic dst_ins = !hit_dst && !rd_q.valid && room && !perm_any;
  wire logic [PIW-1:0] perm_idx = mgmt.index[PIW-1:0];

  for (genvar i = 0; i < PERM_DEPTH; i++) begin : g_perm
    assign perm_hit[i] = perm_tab[i].valid && perm_tab[i].mac == frame_q.dst;
    assign perm_port_v[i] = perm_tab[i].port;
  end

  // Scan and frames preempt management; requester holds req until ack
  assign mgmt_take = (state == ST_IDLE) && mgmt.req && !mgmt_ack
                     && !frame_take && !scan_pend;
  assign perm_we = mgmt_take && mgmt.perm && mgmt.write;

  lbt_timer u_learn (
    .ref_clk(ref_clk), .reset_n(reset_n),
    .run(selftest_done && !forwarding_mode && state != ST_CLEAR),
    .period(learn_cycles), .tick(learn_tick)
  );
  lbt_timer u_age (
    .ref_clk(ref_clk), .reset_n(reset_n), .run(state != ST_CLEAR),
    .period(age_cycles), .tick(age_tick)
  );

  always_comb begin
    next_state = state;
    next_rd_addr = rd_addr;
    next_idx = idx;
    next_count = dyn_count;
    next_dec = '0;
    wr_en = 1'b0;
    wr_addr = rd_addr;
    wr_data = rd_q;
    next_scan_pend = scan_pend || age_tick;
    unique case (state)
      ST_CLEAR: begin
        wr_en = 1'b1;
        wr_addr = idx;
        wr_data = '0;
        next_idx = idx + 1'b1;
        if (idx == LAST) next_state = ST_IDLE;
      end
      ST_IDLE: begin
        if (frame_take) begin
          next_state = ST_SRC_WAIT;
        end else if (scan_pend) begin
          next_scan_pend = age_tick;
          next_idx = '0;
          next_rd_addr = '0;
          next_state = ST_SCAN_WAIT;
        end else if (mgmt_take && !mgmt.perm) begin
          next_rd_addr = mgmt.index[AW-1:0];
          next_state = ST_MGMT_WAIT;
        end
      end
      // Captured header is only valid now, so the source slot is read here
      ST_SRC_WAIT: begin
        next_rd_addr = src_h[AW-1:0];
        next_state = ST_SRC_CHK;
      end
      ST_SRC_CHK: begin
        if (hit_src || src_ins) begin
          wr_en = 1'b1;
          wr_data = '{valid: 1'b1, mac: frame_q.src, port: frame_q.port,
                      known: 1'b1, fresh: 1'b1};
        end
        if (src_ins) next_count = dyn_count + 1'b1;
        if (forwarding_mode) begin
          next_rd_addr = dst_h[AW-1:0];
          next_state = ST_DST_WAIT;
        end else begin
          next_dec = '{valid: 1'b1, forward: 1'b0,
                       out_port: frame_q.port, in_port: frame_q.port};
          next_state = ST_IDLE;
        end
      end
      ST_DST_WAIT: next_state = ST_DST_CHK;
      ST_DST_CHK: begin
        next_dec = '{valid: 1'b1,
                     forward: !dst_known || dst_port != frame_q.port,
                     out_port: dst_known ? dst_port : !frame_q.port,
                     in_port: frame_q.port};
        if (hit_dst) begin
          wr_en = 1'b1;
          wr_data.fresh = 1'b1;
        end else if (dst_ins) begin
          wr_en = 1'b1;
          wr_data = '{valid: 1'b1, mac: frame_q.dst, port: !frame_q.port,
                      known: 1'b0, fresh: 1'b1};
          next_count = dyn_count + 1'b1;
        end
        next_state = ST_IDLE;
      end
      ST_SCAN_WAIT: next_state = ST_SCAN_CHK;
      ST_SCAN_CHK: begin
        // Only the dynamic table is walked, permanent stays put
        wr_addr = idx;
        if (rd_q.valid) begin
          wr_en = 1'b1;
          wr_data.fresh = 1'b0;
          if (!rd_q.fresh) begin
            wr_data.valid = 1'b0;
            next_count = dyn_count - 1'b1;
          end
        end
        next_idx = idx + 1'b1;
        next_rd_addr = idx + 1'b1;
        next_state = (idx == LAST) ? ST_IDLE : ST_SCAN_WAIT;
      end
      ST_MGMT_WAIT: next_state = ST_MGMT_DO;
      ST_MGMT_DO: begin
        if (mgmt.write) begin
          wr_en = 1'b1;
          wr_data = mgmt.entry;
          if (mgmt.entry.valid && !rd_q.valid) begin
            next_count = dyn_count + 1'b1;
          end else if (!mgmt.entry.valid && rd_q.valid) begin
            next_count = dyn_count - 1'b1;
          end
        end
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    rd_q <= dyn_mem[next_rd_addr];
    if (wr_en) dyn_mem[wr_addr] <= wr_data;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < PERM_DEPTH; i++) perm_tab[i] <= '0;
    end else if (perm_we) begin
      perm_tab[perm_idx] <= mgmt.entry;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (frame_take) frame_q <= frame;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state <= ST_CLEAR;
      rd_addr <= '0;
      idx <= '0;
      dyn_count <= '0;
      scan_pend <= 1'b0;
      frame_ready <= 1'b0;
      decision <= '0;
      forwarding_mode <= 1'b0;
    end else begin
      state <= next_state;
      rd_addr <= next_rd_addr;
      idx <= next_idx;
      dyn_count <= next_count;
      scan_pend <= next_scan_pend;
      // Pending aging beats frames so scans cannot starve
      frame_ready <= next_state == ST_IDLE && !next_scan_pend;
      decision <= next_dec;
      if (learn_tick) forwarding_mode <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      mgmt_ack <= 1'b0;
      mgmt_rdata <= '0;
    end else begin
      mgmt_ack <= (mgmt_take && mgmt.perm) || state == ST_MGMT_DO;
      if (mgmt_take && mgmt.perm) mgmt_rdata <= perm_tab[perm_idx];
      else if (state == ST_MGMT_DO) mgmt_rdata <= rd_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      alarm_armed <= 1'b1;
      table_full_alarm <= 1'b0;
    end else begin
      table_full_alarm <= alarm_armed && dyn_count == FULL;
      if (dyn_count == FULL) alarm_armed <= 1'b0;
      else if (dyn_count <= REARM) alarm_armed <= 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  property p_learn_only;
    decision.valid && !$past(forwarding_mode) |-> !decision.forward;
  endproperty
  a_learn_only: assert property (p_learn_only)
    else $error("frame forwarded during learn-only interval");
  property p_src_rec;
    state == ST_SRC_CHK && (hit_src || src_ins) |-> wr_en
      && wr_data.mac == frame_q.src && wr_data.port == frame_q.port
      && wr_data.known && wr_data.fresh;
  endproperty
  a_src_rec: assert property (p_src_rec)
    else $error("source not recorded with arrival port");
  property p_order;
    state == ST_DST_CHK |-> $past(state, 2) == ST_SRC_CHK;
  endproperty
  a_order: assert property (p_order)
    else $error("destination checked before source");
  property p_local;
    state == ST_DST_CHK && dst_known && dst_port == frame_q.port
      |=> decision.valid && !decision.forward;
  endproperty
  a_local: assert property (p_local)
    else $error("local frame not discarded");
  property p_unknown;
    state == ST_DST_CHK && !dst_known |=> decision.forward
      && decision.out_port != decision.in_port;
  endproperty
  a_unknown: assert property (p_unknown)
    else $error("unknown destination not forwarded");
  property p_unk_ins;
    state == ST_DST_CHK && dst_ins |-> wr_en && !wr_data.known
      ##1 dyn_count == $past(dyn_count) + 1'b1;
  endproperty
  a_unk_ins: assert property (p_unk_ins)
    else $error("unknown destination not logged");
  property p_remote;
    state == ST_DST_CHK && dst_known && dst_port != frame_q.port
      |=> decision.forward && decision.out_port == $past(dst_port);
  endproperty
  a_remote: assert property (p_remote)
    else $error("remote frame sent to wrong port");
  property p_fresh;
    state == ST_DST_CHK && hit_dst |-> wr_en && wr_data.fresh;
  endproperty
  a_fresh: assert property (p_fresh)
    else $error("looked-up entry not refreshed");
  property p_age;
    state == ST_SCAN_CHK && rd_q.valid && !rd_q.fresh |-> wr_en
      && !wr_data.valid ##1 dyn_count + 1'b1 == $past(dyn_count);
  endproperty
  a_age: assert property (p_age)
    else $error("stale entry not purged");
  property p_perm_kept;
    !perm_we |=> $stable(perm_tab[0]);
  endproperty
  a_perm_kept: assert property (p_perm_kept)
    else $error("permanent table changed outside management");
  property p_full;
    state == ST_SRC_CHK && !hit_src && !room |-> !wr_en;
  endproperty
  a_full: assert property (p_full)
    else $error("insert into full table");
  property p_alarm;
    table_full_alarm |-> $past(dyn_count) == FULL ##1 !table_full_alarm;
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("table-full alarm wrong");
  property p_perm_pref;
    state == ST_DST_CHK && perm_any && perm_port != frame_q.port
      |=> decision.out_port == $past(perm_port);
  endproperty
  a_perm_pref: assert property (p_perm_pref)
    else $error("permanent port not preferred");

  c_fwd: cover property (decision.valid && decision.forward);
  c_drop: cover property (state == ST_DST_CHK && dst_known
                          && dst_port == frame_q.port);
  c_purge: cover property (state == ST_SCAN_CHK && rd_q.valid && !rd_q.fresh);
  c_alarm: cover property (table_full_alarm);
endmodule : lbt_bridge
`default_nettype wire

// ---- lbt_mac_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module lbt_mac_model (
  input wire logic ref_clk,
  input wire logic frame_ready,
  output var lbt_pkg::lbt_frame_type frame,
  output logic frame_valid
);
  import lbt_pkg::*;

  initial begin
    frame = '0;
    frame_valid = 1'b0;
  end

  // Header held until taken, then scrambled so stale fields never match
  task automatic send(input logic [47:0] dst, input logic [47:0] src,
                      input logic port);
    int k;
    @(posedge ref_clk);
    frame <= {dst, src, port};
    frame_valid <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (frame_ready !== 1'b1 && k < 500);
    frame_valid <= 1'b0;
    frame <= ~{dst, src, port};
  endtask : send
endmodule : lbt_mac_model
`default_nettype wire

// ---- lbt_timer.sv ----
package lbt_pkg;
  localparam int LBT_DYN_DEPTH = 2048;
  localparam int LBT_PERM_DEPTH = 16;
  localparam int LBT_MAC_W = 48;
  localparam int LBT_IDX_W = 11;
  localparam int LBT_HASH_W = 16;
  localparam int LBT_REARM_NUM = 1;
  localparam int LBT_REARM_DEN = 3;
  localparam int LBT_CNT_W = 32;

  typedef struct packed {
    logic valid;
    logic [LBT_MAC_W-1:0] mac;
    logic port;
    logic known;
    logic fresh;
  } lbt_entry_type;

  typedef struct packed {
    logic [LBT_MAC_W-1:0] dst;
    logic [LBT_MAC_W-1:0] src;
    logic port;
  } lbt_frame_type;

  typedef struct packed {
    logic valid;
    logic forward;
    logic out_port;
    logic in_port;
  } lbt_dec_type;

  typedef struct packed {
    logic req;
    logic write;
    logic perm;
    logic [LBT_IDX_W-1:0] index;
    lbt_entry_type entry;
  } lbt_mgmt_type;

  function automatic logic [LBT_HASH_W-1:0] lbt_hash(
      input logic [LBT_MAC_W-1:0] mac);
    lbt_hash = mac[47:32] ^ mac[31:16] ^ mac[15:0];
  endfunction : lbt_hash
endpackage : lbt_pkg

`timescale 1ns/1ps
`default_nettype none
module lbt_timer #(
  parameter int W = lbt_pkg::LBT_CNT_W
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic [W-1:0] period,
  output logic tick
);
  import lbt_pkg::*;
  logic [W-1:0] count;
  wire logic expire = run && (count + 1'b1 >= period);

  always_ff @(posedge ref_clk) begin
    if (!reset_n || !run || expire) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      tick <= 1'b0;
    end else begin
      tick <= expire;
    end
  end
endmodule : lbt_timer
`default_nettype wire

// ---- tb_learning_bridge_address_table.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_learning_bridge_address_table;
  import lbt_pkg::*;
  // Small table keeps the clear, scan and fill short
  localparam int DEPTH = 64;
  localparam logic [47:0] MA = 48'h0000_0000_0011;
  localparam logic [47:0] MB = 48'h0000_0000_0022;
  localparam logic [47:0] MC = 48'h0000_0000_0033;
  localparam logic [47:0] MD = 48'h0000_0000_0044;
  localparam logic [47:0] ME = 48'h0000_0000_00EE;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic selftest_done = 1'b0;
  logic [31:0] learn_cycles = 32'h0000_0032;
  logic [31:0] age_cycles = 32'hFFFF_FFFF;
  lbt_frame_type frame;
  logic frame_valid;
  logic frame_ready;
  lbt_dec_type decision;
  lbt_mgmt_type mgmt = '0;
  logic mgmt_ack;
  lbt_entry_type mgmt_rdata;
  lbt_entry_type rd;
  logic forwarding_mode;
  logic table_full_alarm;
  logic [6:0] dyn_count;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  int n_alarm = 0;

  always #20 ref_clk = ~ref_clk;

  lbt_bridge #(.DYN_DEPTH(DEPTH)) i_dut (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .selftest_done(selftest_done),
    .learn_cycles(learn_cycles),
    .age_cycles(age_cycles),
    .frame(frame),
    .frame_valid(frame_valid),
    .frame_ready(frame_ready),
    .decision(decision),
    .mgmt(mgmt),
    .mgmt_ack(mgmt_ack),
    .mgmt_rdata(mgmt_rdata),
    .forwarding_mode(forwarding_mode),
    .table_full_alarm(table_full_alarm),
    .dyn_count(dyn_count)
  );

  lbt_mac_model i_mac (
    .ref_clk(ref_clk),
    .frame_ready(frame_ready),
    .frame(frame),
    .frame_valid(frame_valid)
  );

  task automatic conclude();
    if (fails == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [63:0] seen, input logic [63:0] exp,
                       input string what);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask : check

  always @(posedge ref_clk) begin
    cycles++;
    if (table_full_alarm === 1'b1) n_alarm++;
    if (cycles == 6000) begin
      fails++;
      $display("MISMATCH %0t run timed out", $time);
      conclude();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  task automatic xfer(input logic [47:0] dst, input logic [47:0] src,
                      input logic port, input logic fwd, input logic outp);
    int k;
    i_mac.send(dst, src, port);
    k = 0;
    do begin
      @(posedge ref_clk);
      #1;
      k++;
    end while (decision.valid !== 1'b1 && k < 20);
    check(decision.valid, 1'b1, "no decision");
    check(decision.forward, fwd, "forward flag");
    check(decision.in_port, port, "arrival port");
    if (fwd) check(decision.out_port, outp, "output port");
  endtask : xfer

  // Request held until the ack edge, dropped in the cycle after it
  task automatic mg(input logic w, input logic p, input logic [10:0] idx,
                    input lbt_entry_type e);
    int k;
    @(posedge ref_clk);
    mgmt <= {1'b1, w, p, idx, e};
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (mgmt_ack !== 1'b1 && k < 400);
    check(mgmt_ack, 1'b1, "no management ack");
    mgmt <= '0;
    rd = mgmt_rdata;
  endtask : mg

  initial begin
    tick(20);
    reset_n <= 1'b1;
    selftest_done <= 1'b1;
    xfer(MB, MA, 1'b0, 1'b0, 1'b0);
    check(forwarding_mode, 1'b0, "still learning");
    for (int k = 0; k < 300 && forwarding_mode !== 1'b1; k++) tick(1);
    check(forwarding_mode, 1'b1, "forwarding not entered");
    xfer(MA, MB, 1'b1, 1'b1, 1'b0);
    xfer(MA, MC, 1'b0, 1'b0, 1'b0);
    xfer(MD, MA, 1'b0, 1'b1, 1'b1);
    mg(1'b0, 1'b0, 11'h004, '0);
    check(rd, {1'b1, MD, 1'b1, 1'b0, 1'b1}, "unknown entry");
    xfer(MA, MD, 1'b1, 1'b1, 1'b0);
    xfer(MD, MB, 1'b1, 1'b0, 1'b0);
    mg(1'b0, 1'b0, 11'h011, '0);
    check(rd, {1'b1, MA, 1'b0, 1'b1, 1'b1}, "learned entry");
    xfer(MA, ME, 1'b0, 1'b0, 1'b0);
    mg(1'b1, 1'b1, 11'h000, {1'b1, ME, 1'b1, 1'b1, 1'b0});
    xfer(ME, MC, 1'b0, 1'b1, 1'b1);
    @(posedge ref_clk);
    age_cycles <= 32'h0000_012C;
    tick(1200);
    age_cycles <= 32'hFFFF_FFFF;
    mg(1'b0, 1'b0, 11'h011, '0);
    check(rd.valid, 1'b0, "stale entry kept");
    mg(1'b0, 1'b1, 11'h000, '0);
    check(rd, {1'b1, ME, 1'b1, 1'b1, 1'b0}, "permanent entry lost");
    xfer(MC, MA, 1'b1, 1'b1, 1'b0);
    mg(1'b0, 1'b0, 11'h011, '0);
    check(rd, {1'b1, MA, 1'b1, 1'b1, 1'b1}, "relearned entry");
    for (int i = 0; i < DEPTH; i++) begin
      xfer(ME, 48'h0000_0000_0100 + 48'(i), 1'b0, 1'b1, 1'b1);
    end
    check(dyn_count, DEPTH, "table not full");
    check(n_alarm, 1, "full alarm count");
    xfer(48'h0000_0000_0300, 48'h0000_0000_0200, 1'b0, 1'b1, 1'b1);
    check(dyn_count, DEPTH, "count past full");
    check(n_alarm, 1, "alarm repeated");
    conclude();
  end
endmodule : tb_learning_bridge_address_table
`default_nettype wire
